// *** inc/atfd_pkg.sv ***
// task-file decoder constants: modes, offsets, error bits, access kinds
// assumes one system clock; host pins already synchronous to it
package atfd_pkg;
    // access methods
    localparam logic [1:0] MODE_IO = 2'h0;
    localparam logic [1:0] MODE_MEM = 2'h1;
    localparam logic [1:0] MODE_IDE = 2'h2;
    // task-file offsets
    localparam logic [3:0] OFF_DATA = 4'h0;
    localparam logic [3:0] OFF_ERR = 4'h1;
    localparam logic [3:0] OFF_SCNT = 4'h2;
    localparam logic [3:0] OFF_SNUM = 4'h3;
    localparam logic [3:0] OFF_CYLL = 4'h4;
    localparam logic [3:0] OFF_CYLH = 4'h5;
    localparam logic [3:0] OFF_HEAD = 4'h6;
    localparam logic [3:0] OFF_STAT = 4'h7;
    localparam logic [3:0] OFF_DEVEN = 4'h8;
    localparam logic [3:0] OFF_DODD = 4'h9;
    localparam logic [3:0] OFF_DERR = 4'hd;
    localparam logic [3:0] OFF_ALT = 4'he;
    localparam logic [3:0] OFF_DADR = 4'hf;
    // native control block addresses, memory window bit, address width
    localparam logic [2:0] IDE_ALT_ADDR = 3'h6;
    localparam logic [2:0] IDE_DADR_ADDR = 3'h7;
    localparam int MEM_WIN_BIT = 10;
    localparam int ADDR_W = 11;
    // error register bits
    localparam int BIT_BBK = 7;
    localparam int BIT_UNC = 6;
    localparam int BIT_SECTOR_NOT_FOUND_FLAG = 4;
    localparam int BIT_COMMAND_ABORTED_FLAG = 2;
    localparam int BIT_GENERAL_ERROR_FLAG = 0;
    localparam logic [7:0] ERR_ZERO_MASK = 8'h2a;
    // reset values and sector count
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] ZERO_COUNT = 8'h00;
    localparam logic [8:0] FULL_SECTORS = 9'h100;
    // buffer shape
    localparam int FIFO_W = 16;
    localparam int FIFO_D = 4;
    // lane use of one access
    typedef enum logic [3:0] {
        K_NONE = 4'h0,
        K_WORD = 4'h1,
        K_EVEN_LO = 4'h2,
        K_ODD_LO = 4'h3,
        K_ODD_HI = 4'h4,
        K_EF_LO = 4'h5,
        K_EF_HI = 4'h6,
        K_REG_LO = 4'h7,
        K_REG_HI = 4'h8
    } atfd_kind_type;
endpackage

// *** design/atfd_task_file.sv ***
// task-file decode, lane steering and data buffering for a flash card
// assumes host strobes and selects are synchronous to clk_sys_i
// Notes on behaviour
// - contiguous I/O: A3..A0 pick sixteen offsets
// - memory window: A10 low offsets, high data bytes
// - native command block: A2..A0 task file
// - native control block 110: alt status, control
// - native DMA acknowledge: word, address ignored
// - native PIO data word unless byte mode enabled
// - data register 16 bit, word on both enables
// - low enable: even/odd by A0; high: odd, except offset 0
// - error/features reached three lane ways
// - offset 0 high-only reaches error/features
// - error read-only, bits 5,3,1 zero
// - bit 7 bad block or CRC error
// - bit 6 uncorrectable, bit 4 id not found
// - bit 2 aborted command
// - bit 0 general error
// - feature register write-only parameters
// - sector count zero means 256
// - count left at remaining sectors
// - status read clears interrupt, alternate not
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// word buffer
// ----------------------------------------
module atfd_fifo #(
    parameter int W = 16,
    parameter int D = 4
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // filling side
    input wire logic [W-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // draining side
    output logic [W-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == AW'(D - 1)) ? '0 : p + AW'(1);
    endfunction

    assign in_ready_o = (cnt_r != (AW+1)'(D));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem_r[rp_r];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= next_ptr(wp_r);
            end
            if (pop) begin
                rp_r <= next_ptr(rp_r);
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ----------------------------------------
// task-file decoder
// ----------------------------------------
module atfd_task_file
    import atfd_pkg::*;
#(
    parameter int DEPTH = atfd_pkg::FIFO_D
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // access method
    input wire logic [1:0] mode_i,
    // host address and selects
    input wire logic reg_space_n_i,
    input wire logic [atfd_pkg::ADDR_W-1:0] addr_i,
    input wire logic low_lane_enable_n_i,
    input wire logic high_lane_enable_n_i,
    input wire logic cmd_block_select_n_i,
    input wire logic ctl_block_select_n_i,
    input wire logic dma_grant_n_i,
    // host strobes
    input wire logic io_read_strobe_n_i,
    input wire logic io_write_strobe_n_i,
    input wire logic mem_read_strobe_n_i,
    input wire logic mem_write_strobe_n_i,
    // host data bus
    input wire logic [15:0] data_i,
    output logic [15:0] data_o,
    output logic data_lo_oe_o,
    output logic data_hi_oe_o,
    output logic host_ready_o,
    // buffer to host
    input wire logic [15:0] rd_word_i,
    input wire logic rd_valid_i,
    output logic rd_ready_o,
    // host to buffer
    output logic [15:0] wr_word_o,
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    // core status and events
    input wire logic byte_mode_i,
    input wire logic [7:0] device_state_i,
    input wire logic [7:0] legacy_unit_address_i,
    input wire logic bad_block_or_crc_flag_i,
    input wire logic uncorrectable_flag_i,
    input wire logic sector_not_found_flag_i,
    input wire logic command_aborted_flag_i,
    input wire logic general_error_flag_i,
    input wire logic err_clear_i,
    input wire logic irq_set_i,
    input wire logic sector_done_i,
    output logic irq_pending_o,
    // task-file contents
    output logic [7:0] failure_detail_o,
    output logic [7:0] command_parameter_o,
    output logic [7:0] transfer_sector_count_o,
    output logic [8:0] sectors_requested_o,
    output logic [7:0] start_sector_low_addr_o,
    output logic [7:0] track_low_addr_o,
    output logic [7:0] track_high_addr_o,
    output logic [7:0] unit_and_head_select_o,
    output logic [7:0] command_code_o,
    output logic command_strobe_o,
    output logic [7:0] interface_control_o
);
    import atfd_pkg::*;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // result: {hit, dma, offset}
    function automatic logic [5:0] decode(input logic [1:0] m,
            input logic regn, input logic [ADDR_W-1:0] a,
            input logic cs0n, input logic cs1n, input logic dakn);
        logic [5:0] r;
        r = '0;
        case (m)
            MODE_IO: begin
                if (!regn) begin
                    r = {2'b10, a[3:0]};
                end
            end
            MODE_MEM: begin
                if (regn && a[MEM_WIN_BIT]) begin
                    r = {2'b10, a[0] ? OFF_DODD : OFF_DEVEN};
                end else if (regn) begin
                    r = {2'b10, a[3:0]};
                end
            end
            MODE_IDE: begin
                if (cs1n && !cs0n && dakn) begin
                    r = {3'b100, a[2:0]};
                end else if (!cs1n && cs0n && dakn &&
                        a[2:0] == IDE_ALT_ADDR) begin
                    r = {2'b10, OFF_ALT};
                end else if (!cs1n && cs0n && dakn &&
                        a[2:0] == IDE_DADR_ADDR) begin
                    r = {2'b10, OFF_DADR};
                end else if (cs1n && cs0n && !dakn) begin
                    r = {2'b11, OFF_DATA};
                end
            end
            default: begin
                r = '0;
            end
        endcase
        decode = r;
    endfunction

    function automatic atfd_kind_type classify(input logic [3:0] off,
            input logic lo, input logic hi, input logic odd);
        atfd_kind_type k;
        k = K_NONE;
        if (off == OFF_DATA || off == OFF_DEVEN || off == OFF_DODD) begin
            if (lo && hi) begin
                k = K_WORD;
            end else if (lo) begin
                k = odd ? K_ODD_LO : K_EVEN_LO;
            end else if (off == OFF_DATA) begin
                k = K_EF_HI;
            end else begin
                k = K_ODD_HI;
            end
        end else if (off == OFF_ERR || off == OFF_DERR) begin
            if (hi && (!lo || off == OFF_DERR)) begin
                k = K_EF_HI;
            end else begin
                k = K_EF_LO;
            end
        end else begin
            k = lo ? K_REG_LO : K_REG_HI;
        end
        classify = k;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [5:0] dec;
    logic is_ide;
    logic lane_lo;
    logic lane_hi;
    logic rd_now;
    logic wr_now;
    logic rd_end;
    logic wr_end;
    atfd_kind_type kind_now;
    logic [7:0] reg_val;
    logic [15:0] rdata;
    logic push_kind;
    logic pop_kind;
    logic rd_prev_r;
    logic wr_prev_r;
    atfd_kind_type acc_kind_r;
    logic [3:0] acc_off_r;
    logic acc_ide_r;
    logic [15:0] wdat_r;
    logic phase_r;
    logic [7:0] wr_even_r;
    logic [7:0] err_r;
    logic [7:0] feat_r;
    logic [7:0] scnt_r;
    logic [7:0] snum_r;
    logic [7:0] cyll_r;
    logic [7:0] cylh_r;
    logic [7:0] head_r;
    logic [7:0] cmd_r;
    logic cmd_pulse_r;
    logic [7:0] devctl_r;
    logic irq_r;
    logic [15:0] rdf_data;
    logic rdf_valid;
    logic wrf_ready;
    logic [7:0] wbyte;

    // ----------------------------------------
    // access detection
    // ----------------------------------------
    always_comb begin
        dec = decode(mode_i, reg_space_n_i, addr_i, cmd_block_select_n_i,
            ctl_block_select_n_i, dma_grant_n_i);
        is_ide = (mode_i == MODE_IDE);
        if (is_ide) begin
            lane_lo = 1'b1;
            lane_hi = dec[4] | (dec[3:0] == OFF_DATA & !byte_mode_i);
        end else begin
            lane_lo = !low_lane_enable_n_i;
            lane_hi = !high_lane_enable_n_i;
        end
        kind_now = classify(dec[3:0], lane_lo, lane_hi,
            is_ide ? phase_r : addr_i[0]);
        rd_now = dec[5] & (lane_lo | lane_hi) &
            !(mode_i == MODE_MEM ? mem_read_strobe_n_i : io_read_strobe_n_i);
        wr_now = dec[5] & (lane_lo | lane_hi) &
            !(mode_i == MODE_MEM ? mem_write_strobe_n_i :
            io_write_strobe_n_i);
    end

    assign rd_end = rd_prev_r & !rd_now;
    assign wr_end = wr_prev_r & !wr_now;
    assign push_kind = (acc_kind_r == K_WORD) | (acc_kind_r == K_ODD_LO) |
        (acc_kind_r == K_ODD_HI);
    assign pop_kind = push_kind;
    assign host_ready_o = !(rd_now && (kind_now == K_WORD ||
        kind_now == K_EVEN_LO || kind_now == K_ODD_LO ||
        kind_now == K_ODD_HI) && !rdf_valid) &&
        !(wr_now && (kind_now == K_WORD || kind_now == K_ODD_LO ||
        kind_now == K_ODD_HI) && !wrf_ready);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
            acc_kind_r <= K_NONE;
            acc_off_r <= OFF_DATA;
            acc_ide_r <= 1'b0;
            wdat_r <= RST_WORD;
        end else begin
            rd_prev_r <= rd_now;
            wr_prev_r <= wr_now;
            if (rd_now || wr_now) begin
                acc_kind_r <= kind_now;
                acc_off_r <= dec[3:0];
                acc_ide_r <= is_ide;
                wdat_r <= data_i;
            end
        end
    end

    // ----------------------------------------
    // read steering
    // ----------------------------------------
    always_comb begin
        case (dec[3:0])
            OFF_SCNT: reg_val = scnt_r;
            OFF_SNUM: reg_val = snum_r;
            OFF_CYLL: reg_val = cyll_r;
            OFF_CYLH: reg_val = cylh_r;
            OFF_HEAD: reg_val = head_r;
            OFF_STAT: reg_val = device_state_i;
            OFF_ALT: reg_val = device_state_i;
            OFF_DADR: reg_val = legacy_unit_address_i;
            default: reg_val = RST_BYTE;
        endcase
        case (kind_now)
            K_WORD: rdata = rdf_data;
            K_EVEN_LO: rdata = {RST_BYTE, rdf_data[7:0]};
            K_ODD_LO: rdata = {RST_BYTE, rdf_data[15:8]};
            K_ODD_HI: rdata = {rdf_data[15:8], RST_BYTE};
            K_EF_LO: rdata = {RST_BYTE, err_r};
            K_EF_HI: rdata = {err_r, RST_BYTE};
            K_REG_LO: rdata = {RST_BYTE, reg_val};
            K_REG_HI: rdata = {reg_val, RST_BYTE};
            default: rdata = RST_WORD;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            data_o <= RST_WORD;
            data_lo_oe_o <= 1'b0;
            data_hi_oe_o <= 1'b0;
        end else begin
            data_o <= rd_now ? rdata : RST_WORD;
            data_lo_oe_o <= rd_now && (kind_now == K_WORD ||
                kind_now == K_EVEN_LO || kind_now == K_ODD_LO ||
                kind_now == K_EF_LO || kind_now == K_REG_LO);
            data_hi_oe_o <= rd_now && (kind_now == K_WORD ||
                kind_now == K_ODD_HI || kind_now == K_EF_HI ||
                kind_now == K_REG_HI);
        end
    end

    // ----------------------------------------
    // buffers
    // ----------------------------------------
    atfd_fifo #(.W(FIFO_W), .D(DEPTH)) u_rd_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .in_data_i(rd_word_i),
        .in_valid_i(rd_valid_i),
        .in_ready_o(rd_ready_o),
        .out_data_o(rdf_data),
        .out_valid_o(rdf_valid),
        .out_ready_i(rd_end & pop_kind)
    );

    atfd_fifo #(.W(FIFO_W), .D(DEPTH)) u_wr_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .in_data_i(acc_kind_r == K_WORD ? wdat_r :
            {acc_kind_r == K_ODD_HI ? wdat_r[15:8] : wdat_r[7:0],
            wr_even_r}),
        .in_valid_i(wr_end & push_kind),
        .in_ready_o(wrf_ready),
        .out_data_o(wr_word_o),
        .out_valid_o(wr_valid_o),
        .out_ready_i(wr_ready_i)
    );

    // even byte held until its odd partner arrives
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wr_even_r <= RST_BYTE;
        end else if (wr_end && acc_kind_r == K_EVEN_LO) begin
            wr_even_r <= wdat_r[7:0];
        end
    end

    // native byte mode pairs even then odd
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !byte_mode_i) begin
            phase_r <= 1'b0;
        end else if ((rd_end || wr_end) && acc_ide_r &&
                (acc_kind_r == K_EVEN_LO || acc_kind_r == K_ODD_LO)) begin
            phase_r <= !phase_r;
        end
    end

    // ----------------------------------------
    // task-file writes
    // ----------------------------------------
    assign wbyte = (acc_kind_r == K_REG_HI) ? wdat_r[15:8] : wdat_r[7:0];

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            feat_r <= RST_BYTE;
        end else if (wr_end && acc_kind_r == K_EF_LO) begin
            feat_r <= wdat_r[7:0];
        end else if (wr_end && acc_kind_r == K_EF_HI) begin
            feat_r <= wdat_r[15:8];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            snum_r <= RST_BYTE;
            cyll_r <= RST_BYTE;
            cylh_r <= RST_BYTE;
            head_r <= RST_BYTE;
            cmd_r <= RST_BYTE;
            cmd_pulse_r <= 1'b0;
            devctl_r <= RST_BYTE;
        end else begin
            cmd_pulse_r <= 1'b0;
            if (wr_end && (acc_kind_r == K_REG_LO ||
                    acc_kind_r == K_REG_HI)) begin
                case (acc_off_r)
                    OFF_SNUM: snum_r <= wbyte;
                    OFF_CYLL: cyll_r <= wbyte;
                    OFF_CYLH: cylh_r <= wbyte;
                    OFF_HEAD: head_r <= wbyte;
                    OFF_STAT: begin
                        cmd_r <= wbyte;
                        cmd_pulse_r <= 1'b1;
                    end
                    OFF_ALT: devctl_r <= wbyte;
                    default: cmd_pulse_r <= 1'b0;
                endcase
            end
        end
    end

    // host write wins over a core decrement
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            scnt_r <= ZERO_COUNT;
        end else if (wr_end && acc_off_r == OFF_SCNT &&
                (acc_kind_r == K_REG_LO || acc_kind_r == K_REG_HI)) begin
            scnt_r <= wbyte;
        end else if (sector_done_i) begin
            scnt_r <= scnt_r - 8'h01;
        end
    end

    // ----------------------------------------
    // error bits and interrupt
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            err_r <= RST_BYTE;
        end else begin
            if (err_clear_i) begin
                err_r <= RST_BYTE;
            end
            if (bad_block_or_crc_flag_i) begin
                err_r[BIT_BBK] <= 1'b1;
            end
            if (uncorrectable_flag_i) begin
                err_r[BIT_UNC] <= 1'b1;
            end
            if (sector_not_found_flag_i) begin
                err_r[BIT_SECTOR_NOT_FOUND_FLAG] <= 1'b1;
            end
            if (command_aborted_flag_i) begin
                err_r[BIT_COMMAND_ABORTED_FLAG] <= 1'b1;
            end
            if (general_error_flag_i) begin
                err_r[BIT_GENERAL_ERROR_FLAG] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_r <= 1'b0;
        end else if (irq_set_i) begin
            irq_r <= 1'b1;
        end else if (rd_end && acc_off_r == OFF_STAT &&
                (acc_kind_r == K_REG_LO || acc_kind_r == K_REG_HI)) begin
            irq_r <= 1'b0;
        end
    end

    assign irq_pending_o = irq_r;
    assign failure_detail_o = err_r & ~ERR_ZERO_MASK;
    assign command_parameter_o = feat_r;
    assign transfer_sector_count_o = scnt_r;
    assign sectors_requested_o = (scnt_r == ZERO_COUNT) ? FULL_SECTORS :
        {1'b0, scnt_r};
    assign start_sector_low_addr_o = snum_r;
    assign track_low_addr_o = cyll_r;
    assign track_high_addr_o = cylh_r;
    assign unit_and_head_select_o = head_r;
    assign command_code_o = cmd_r;
    assign command_strobe_o = cmd_pulse_r;
    assign interface_control_o = devctl_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_end_reg(logic e, logic [3:0] o);
        e && acc_off_r == o && acc_kind_r == K_REG_LO;
    endsequence

    AST_ERR_ZERO: assert property (
        (failure_detail_o & ERR_ZERO_MASK) == RST_BYTE)
        else $error("reserved error bits not zero");
    AST_BBK: assert property (bad_block_or_crc_flag_i |=>
        failure_detail_o[BIT_BBK])
        else $error("bad block bit not set");
    AST_SECTOR_NOT_FOUND_FLAG: assert property (sector_not_found_flag_i |=>
        failure_detail_o[BIT_SECTOR_NOT_FOUND_FLAG])
        else $error("id not found bit not set");
    AST_COMMAND_ABORTED_FLAG: assert property (command_aborted_flag_i |=>
        failure_detail_o[BIT_COMMAND_ABORTED_FLAG])
        else $error("abort bit not set");
    AST_STAT_CLR: assert property (
        s_end_reg(rd_end && !irq_set_i, OFF_STAT) |=> !irq_pending_o)
        else $error("status read kept interrupt");
    AST_ALT_KEEP: assert property (
        s_end_reg(rd_end && irq_pending_o, OFF_ALT) |=> irq_pending_o)
        else $error("alt status read cleared interrupt");
    AST_CMD: assert property (s_end_reg(wr_end, OFF_STAT) |=>
        command_strobe_o && command_code_o == $past(wdat_r[7:0]) ##1
        !command_strobe_o)
        else $error("command write not taken");
    AST_DMA_WORD: assert property (rd_now && dec[4] |=>
        data_lo_oe_o && data_hi_oe_o)
        else $error("dma read not a word");
    AST_UNDEF: assert property (rd_now && kind_now == K_REG_LO &&
        dec[3:0] inside {4'ha, 4'hb, 4'hc} |=> data_o == RST_WORD)
        else $error("undefined offset read not zero");
    AST_SC256: assert property (
        transfer_sector_count_o == ZERO_COUNT |->
        sectors_requested_o == FULL_SECTORS)
        else $error("zero count not 256");
    AST_FEAT: assert property (wr_end && acc_kind_r == K_EF_LO |=>
        command_parameter_o == $past(wdat_r[7:0]))
        else $error("feature write lost");
endmodule

`default_nettype wire

// *** testbench/atfd_host_model.sv ***
// host bus model: drives selects, address, strobes and write data
// assumes clk_sys_i runs; every access starts at a falling edge
`timescale 1ns/1ps
`default_nettype none
module atfd_host_model (
    // clock and mode
    input wire logic clk_sys_i,
    input wire logic [1:0] mode_i,
    // selects and address
    output logic reg_space_n_i, output logic [10:0] addr_i,
    output logic low_lane_enable_n_i, output logic high_lane_enable_n_i,
    output logic cmd_block_select_n_i, output logic ctl_block_select_n_i,
    output logic dma_grant_n_i,
    // strobes and data
    output logic io_read_strobe_n_i, output logic io_write_strobe_n_i,
    output logic mem_read_strobe_n_i, output logic mem_write_strobe_n_i,
    output logic [15:0] data_i,
    input wire logic [15:0] data_o
);
    initial begin
        {io_read_strobe_n_i, io_write_strobe_n_i} = 2'h3;
        {mem_read_strobe_n_i, mem_write_strobe_n_i} = 2'h3;
        {cmd_block_select_n_i, ctl_block_select_n_i, dma_grant_n_i} = 3'h7;
        {low_lane_enable_n_i, high_lane_enable_n_i} = 2'h3;
        reg_space_n_i = 1'b0;
        addr_i = 11'h000;
        data_i = 16'h0000;
    end

    // one access; s = {ctl_n, cmd_n, lo_n, hi_n}
    task automatic acc(input logic w, input logic [10:0] a,
        input logic [3:0] s, input logic [15:0] d, output logic [15:0] q);
        @(negedge clk_sys_i);
        reg_space_n_i = (mode_i == 2'h1);
        addr_i = a;
        {ctl_block_select_n_i, cmd_block_select_n_i} = s[3:2];
        {low_lane_enable_n_i, high_lane_enable_n_i} = s[1:0];
        data_i = d;
        if (mode_i == 2'h1)
            {mem_write_strobe_n_i, mem_read_strobe_n_i} = w ? 2'h1 : 2'h2;
        else
            {io_write_strobe_n_i, io_read_strobe_n_i} = w ? 2'h1 : 2'h2;
        @(negedge clk_sys_i);
        q = data_o;
        {io_read_strobe_n_i, io_write_strobe_n_i} = 2'h3;
        {mem_read_strobe_n_i, mem_write_strobe_n_i} = 2'h3;
        // released bus: no stale value left behind
        data_i = ~d;
        @(negedge clk_sys_i);
        {ctl_block_select_n_i, cmd_block_select_n_i} = 2'h3;
        {low_lane_enable_n_i, high_lane_enable_n_i} = 2'h3;
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// bench for the task-file decoder: registers, error bits, buffer
// assumes atfd_host_model drives the host pins
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import atfd_pkg::*;
    localparam logic [3:0] LO = 4'hd, HI = 4'he, BOTH = 4'hc;
    localparam logic [3:0] IDE = 4'hb, IDEC = 4'h7;
    logic clk_sys_i = 0, rst_i = 1, rd_valid_i = 0, wr_ready_i = 0;
    logic byte_mode_i = 0, err_clear_i = 0, irq_set_i = 0, sector_done_i = 0;
    logic bad_block_or_crc_flag_i = 0, uncorrectable_flag_i = 0;
    logic sector_not_found_flag_i = 0, command_aborted_flag_i = 0;
    logic general_error_flag_i = 0, reg_space_n_i, low_lane_enable_n_i;
    logic high_lane_enable_n_i, cmd_block_select_n_i, ctl_block_select_n_i;
    logic dma_grant_n_i, io_read_strobe_n_i, io_write_strobe_n_i;
    logic mem_read_strobe_n_i, mem_write_strobe_n_i, data_lo_oe_o;
    logic data_hi_oe_o, host_ready_o, rd_ready_o, wr_valid_o, irq_pending_o;
    logic command_strobe_o;
    logic [1:0] mode_i = 0;
    logic [7:0] device_state_i = 8'h50, legacy_unit_address_i = 8'h00;
    logic [7:0] failure_detail_o, command_parameter_o, transfer_sector_count_o;
    logic [7:0] start_sector_low_addr_o, track_low_addr_o, track_high_addr_o;
    logic [7:0] unit_and_head_select_o, command_code_o, interface_control_o;
    logic [8:0] sectors_requested_o;
    logic [10:0] addr_i;
    logic [15:0] data_i, data_o, rd_word_i = 0, wr_word_o, q;
    int error_cnt = 0, comparisons = 0, n = 0;

    always #5 clk_sys_i = ~clk_sys_i;
    atfd_task_file atfd_task_file_i (.*);
    atfd_host_model atfd_host_model_i (.*);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] s, e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [10:0] a, input logic [3:0] s,
        input logic [15:0] d16);
        atfd_host_model_i.acc(1'b1, a, s, 16'(d16), q);
    endtask
    task automatic rd(input logic [10:0] a, input logic [3:0] s);
        atfd_host_model_i.acc(1'b0, a, s, 16'h0000, q);
    endtask
    // events: flags 7..3, clear, irq, sector done
    task automatic ev(input logic [7:0] v);
        @(negedge clk_sys_i);
        {bad_block_or_crc_flag_i, uncorrectable_flag_i, sector_not_found_flag_i,
            command_aborted_flag_i, general_error_flag_i, err_clear_i,
            irq_set_i, sector_done_i} = v;
    endtask
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_count;
        chk("req0", 16'(sectors_requested_o), 16'h0100);
        wr(11'h2, LO, 16'h0005);
        ev(8'h01);
        ev(8'h00);
        chk("cnt", 16'(transfer_sector_count_o), 16'h0004);
    endtask
    task automatic t_err;
        ev(8'hf8);
        ev(8'h00);
        wr(11'h1, LO, 16'h003c);
        chk("err", 16'(failure_detail_o), 16'h00d5);
        chk("feat", 16'(command_parameter_o), 16'h003c);
        rd(11'h1, LO);
        chk("err lo", q, 16'h00d5);
        rd(11'h0, HI);
        chk("err hi", q, 16'hd500);
        rd(11'hd, BOTH);
        chk("err d", q, 16'hd500);
        ev(8'h04);
        ev(8'h00);
        chk("clr", 16'(failure_detail_o), 16'h0000);
    endtask
    task automatic t_irq;
        ev(8'h02);
        ev(8'h00);
        rd(11'he, LO);
        chk("alt", q, 16'h0050);
        chk("irq alt", 16'(irq_pending_o), 16'h0001);
        rd(11'h7, LO);
        chk("irq st", 16'(irq_pending_o), 16'h0000);
        rd(11'ha, LO);
        chk("undef", q, 16'h0000);
        wr(11'h7, LO, 16'h00ec);
        chk("cmd", 16'(command_code_o), 16'h00ec);
    endtask
    task automatic t_modes;
        mode_i = 2'h1;
        wr(11'h3f3, LO, 16'h0011);
        chk("mem", 16'(start_sector_low_addr_o), 16'h0011);
        mode_i = 2'h2;
        wr(11'h4, IDE, 16'h0022);
        chk("ide", 16'(track_low_addr_o), 16'h0022);
        wr(11'h6, IDEC, 16'h0006);
        chk("ctl", 16'(interface_control_o), 16'h0006);
        mode_i = 2'h0;
    endtask
    task automatic t_fifo;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_sys_i);
            rd_valid_i = rd_ready_o;
            rd_word_i = 16'ha000 + 16'(n);
            n += int'(rd_ready_o);
        end
        chk("fill", 16'(n), 16'(FIFO_D));
        for (int i = 0; i < 4; i++) begin
            rd(i == 1 ? 11'h8 : i == 2 ? 11'h9 : 11'h0, BOTH);
            chk("word", q, 16'ha000 + 16'(i));
        end
        wr(11'h0, BOTH, 16'h5a3c);
        chk("wword", wr_word_o, 16'h5a3c);
        chk("wvalid", 16'(wr_valid_o), 16'h0001);
    endtask

    initial begin
        repeat (3) @(negedge clk_sys_i);
        rst_i = 0;
        t_count;
        t_err;
        t_irq;
        t_modes;
        t_fifo;
        report_and_stop;
    end
endmodule
`default_nettype wire
